// File: hw/vector_map_pkg.sv
/*
 * Holds the constants of the reset and interrupt vector map: vector addresses,
 * source indices, widths and reset values.
 * Assumes a one-word-per-vector program memory addressed in words.
 */
package vector_map_pkg;
    // ==========================================================
    // Widths
    localparam int unsigned ADDR_W      = 12;   // Program word address width
    localparam int unsigned SRC_COUNT   = 25;   // Interrupt sources (vectors 0x001..0x019)
    localparam int unsigned SRC_IDX_W   = 5;    // Width of a source index

    // ==========================================================
    // Fixed vector addresses
    localparam logic [ADDR_W-1:0] RESET_VECTOR      = 12'h000; // Default reset entry
    localparam logic [ADDR_W-1:0] TABLE_BASE        = 12'h001; // First interrupt vector
    localparam logic [ADDR_W-1:0] LAST_VECTOR       = 12'h019; // Program store ready vector
    localparam logic [ADDR_W-1:0] BOOT_START_RESET  = 12'hc00; // Boot section start after reset

    // ==========================================================
    // Source indices; vector address is TABLE_BASE + index
    localparam logic [SRC_IDX_W-1:0] SRC_EXT_ZERO     = 5'h00; // 0x001
    localparam logic [SRC_IDX_W-1:0] SRC_EXT_ONE      = 5'h01; // 0x002
    localparam logic [SRC_IDX_W-1:0] SRC_PIN_ZERO     = 5'h02; // 0x003
    localparam logic [SRC_IDX_W-1:0] SRC_PIN_ONE      = 5'h03; // 0x004
    localparam logic [SRC_IDX_W-1:0] SRC_PIN_TWO      = 5'h04; // 0x005
    localparam logic [SRC_IDX_W-1:0] SRC_WATCHDOG     = 5'h05; // 0x006
    localparam logic [SRC_IDX_W-1:0] SRC_T2_MATCH_A   = 5'h06; // 0x007
    localparam logic [SRC_IDX_W-1:0] SRC_T2_OVF       = 5'h08; // 0x009
    localparam logic [SRC_IDX_W-1:0] SRC_T1_CAPTURE   = 5'h09; // 0x00A
    localparam logic [SRC_IDX_W-1:0] SRC_T1_OVF       = 5'h0c; // 0x00D
    localparam logic [SRC_IDX_W-1:0] SRC_T0_MATCH_A   = 5'h0d; // 0x00E
    localparam logic [SRC_IDX_W-1:0] SRC_T0_OVF       = 5'h0f; // 0x010
    localparam logic [SRC_IDX_W-1:0] SRC_SPI_DONE     = 5'h10; // 0x011
    localparam logic [SRC_IDX_W-1:0] SRC_SER_RX       = 5'h11; // 0x012
    localparam logic [SRC_IDX_W-1:0] SRC_SER_TX       = 5'h13; // 0x014
    localparam logic [SRC_IDX_W-1:0] SRC_CONV_DONE    = 5'h14; // 0x015
    localparam logic [SRC_IDX_W-1:0] SRC_NVM_READY    = 5'h15; // 0x016
    localparam logic [SRC_IDX_W-1:0] SRC_STORE_READY  = 5'h18; // 0x019

    // ==========================================================
    // Reset values
    localparam logic [ADDR_W-1:0] VEC_RESET_VALUE   = 12'h000; // Vector output in reset

    // ==========================================================
    // Dispatcher states
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,   // Held in reset / pending reset fetch
        ST_BOOT  = 2'b01,   // Presenting reset entry
        ST_RUN   = 2'b10    // Normal interrupt dispatch
    } disp_state_t;
endpackage : vector_map_pkg

// File: hw/lowest_pending.sv
/*
 * Priority picker: finds the lowest-numbered set bit of a request vector.
 * Purely combinational; assumes the caller already masked disabled sources.
 */
`timescale 1ns/10ps
`default_nettype none
module lowest_pending
    import vector_map_pkg::*;
(
    input  wire logic [SRC_COUNT-1:0] req,    // Enabled pending requests
    output logic                      found,  // Any request present
    output logic [SRC_IDX_W-1:0]      index   // Lowest requesting index
);
    // ==========================================================
    // Scan from the top so the lowest index wins
    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = SRC_COUNT - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                index = SRC_IDX_W'(i);
            end
        end
    end
endmodule : lowest_pending
`default_nettype wire

// File: hw/interrupt_vector_map.sv
/*
 * Reset and interrupt vector mapping: turns reset and pending enabled
 * interrupt requests into a one-word program address for the core.
 * Assumes requests arrive from logic on CLK, enables come from the sources'
 * own control bits, and the core pulses VEC_TAKEN when it fetches a vector.
 */
// Overview of operation
// - After any system reset start at 0x000, or at boot start if the fuse is programmed
// - External requests zero/one go to 0x001/0x002
// - Pin changes 0x003-0x005, watchdog at 0x006
// - Second byte timer events at 0x007-0x009
// - Wide timer capture 0x00A, then 0x00B-0x00D
// - First byte timer events at 0x00E-0x010
// - Serial peripheral transfer done at 0x011
// - Serial port events at 0x012-0x014
// - Converter, memory, comparator, two-wire, store 0x015-0x019
// - Programmed boot fuse redirects reset to boot
// - Never dispatch a disabled source's vector
// - Reset and table placed independently
// - Select bit offsets table by boot start
// - Fuse one means unprogrammed, zero programmed
`timescale 1ns/10ps
`default_nettype none
module interrupt_vector_map
    import vector_map_pkg::*;
(
    input  wire logic                 CLK,               // Core clock, 50 MHz
    input  wire logic                 RST,               // Async system reset, active high
    input  wire logic                 BOOT_RESET_FUSE,   // Fuse level, 0 = programmed
    input  wire logic                 VECTOR_SELECT_BIT, // Table moved to boot section
    input  wire logic [ADDR_W-1:0]    BOOT_START,        // Boot section start word
    input  wire logic [SRC_COUNT-1:0] IRQ_PENDING,       // Source flags, index = vector - 1
    input  wire logic [SRC_COUNT-1:0] IRQ_ENABLE,        // Source enable bits
    input  wire logic                 GLOBAL_ENABLE,     // Core global interrupt enable
    input  wire logic                 VEC_TAKEN,         // Core fetched the offered vector
    output logic                      VEC_VALID,         // Vector offered to core
    output logic                      VEC_IS_RESET,      // Offered vector is the reset entry
    output logic [ADDR_W-1:0]         VEC_ADDR,          // Fetch address, registered
    output logic [SRC_IDX_W-1:0]      VEC_SOURCE         // Source index of offer, registered
);
    // ==========================================================
    // State
    typedef struct packed {
        disp_state_t          st;     // Dispatcher state
        logic                 valid;  // Offer standing
        logic                 is_rst; // Offer is reset entry
        logic [ADDR_W-1:0]    addr;   // Offered address
        logic [SRC_IDX_W-1:0] src;    // Offered source
    } vm_state_t;

    vm_state_t s_q;     // Registered state
    vm_state_t s_d;     // Next state

    logic [SRC_COUNT-1:0] live_req;   // Enabled pending requests
    logic                 any_req;    // At least one live request
    logic [SRC_IDX_W-1:0] win_idx;    // Lowest live index
    logic [ADDR_W-1:0]    table_base; // Current table start
    logic [ADDR_W-1:0]    reset_addr; // Current reset entry

    // ==========================================================
    // Masking: a disabled source is never dispatched
    assign live_req = IRQ_PENDING & IRQ_ENABLE;

    // Priority picker, lowest index first
    lowest_pending u_pick (
        .req   (live_req),
        .found (any_req),
        .index (win_idx)
    );

    // ==========================================================
    // Placement: reset entry and table chosen independently
    always_comb begin
        // Fuse low means programmed: reset enters the boot section
        reset_addr = BOOT_RESET_FUSE ? RESET_VECTOR : BOOT_START;
        // Select bit moves the table by the boot start
        table_base = VECTOR_SELECT_BIT ? (BOOT_START + TABLE_BASE) : TABLE_BASE;
    end

    // ==========================================================
    // Dispatcher next-state logic
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            ST_RESET: begin
                // First cycle after reset release: offer the reset entry
                s_d.st     = ST_BOOT;
                s_d.valid  = 1'b1;
                s_d.is_rst = 1'b1;
                s_d.addr   = reset_addr;
                s_d.src    = '0;
            end
            ST_BOOT: begin
                // Hold the reset entry until the core fetches it
                if (VEC_TAKEN) begin
                    s_d.st     = ST_RUN;
                    s_d.valid  = 1'b0;
                    s_d.is_rst = 1'b0;
                end
            end
            ST_RUN: begin
                if (s_q.valid && VEC_TAKEN) begin
                    // Offer consumed; source clears its own flag
                    s_d.valid = 1'b0;
                end else if (!s_q.valid && any_req && GLOBAL_ENABLE) begin
                    // New offer: table base plus source index
                    s_d.valid = 1'b1;
                    s_d.src   = win_idx;
                    s_d.addr  = table_base + {{(ADDR_W-SRC_IDX_W){1'b0}}, win_idx};
                end else if (s_q.valid && !live_req[s_q.src]) begin
                    // Request withdrawn or disabled before fetch
                    s_d.valid = 1'b0;
                end
            end
            default: begin
                s_d.st    = ST_RESET;
                s_d.valid = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q.st     <= ST_RESET;
            s_q.valid  <= 1'b0;
            s_q.is_rst <= 1'b0;
            s_q.addr   <= VEC_RESET_VALUE;
            s_q.src    <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign VEC_VALID    = s_q.valid;
    assign VEC_IS_RESET = s_q.is_rst;
    assign VEC_ADDR     = s_q.addr;
    assign VEC_SOURCE   = s_q.src;

    // ==========================================================
    // Assertions
    // Reset entry follows the fuse level seen on the release edge
    reset_entry_a: assert property (@(posedge CLK) disable iff (RST)
        (s_q.st == ST_RESET) |=> VEC_VALID && VEC_IS_RESET
            && VEC_ADDR == ($past(BOOT_RESET_FUSE) ? 12'h000 : $past(BOOT_START)))
        else $error("Reset entry address wrong");

    // Programmed fuse sends the first fetch to the boot section
    boot_redirect_a: assert property (@(posedge CLK) disable iff (RST)
        (s_q.st == ST_RESET && !BOOT_RESET_FUSE) |=> VEC_ADDR == $past(BOOT_START))
        else $error("Programmed fuse did not redirect reset");

    ext_zero_a: assert property (@(posedge CLK) disable iff (RST)
        (VEC_VALID && !VEC_IS_RESET && !VECTOR_SELECT_BIT && $rose(VEC_VALID)
            && VEC_SOURCE == SRC_EXT_ZERO && !$past(VECTOR_SELECT_BIT)) |-> VEC_ADDR == 12'h001)
        else $error("External zero vector wrong");

    table_map_a: assert property (@(posedge CLK) disable iff (RST)
        ($rose(VEC_VALID) && !VEC_IS_RESET && !$past(VECTOR_SELECT_BIT))
            |-> VEC_ADDR == 12'h001 + {7'h00, VEC_SOURCE})
        else $error("Vector address not table base plus source");

    store_ready_a: assert property (@(posedge CLK) disable iff (RST)
        ($rose(VEC_VALID) && !VEC_IS_RESET && !$past(VECTOR_SELECT_BIT)
            && VEC_SOURCE == SRC_STORE_READY) |-> VEC_ADDR == 12'h019)
        else $error("Store ready vector wrong");

    moved_table_a: assert property (@(posedge CLK) disable iff (RST)
        ($rose(VEC_VALID) && !VEC_IS_RESET && $past(VECTOR_SELECT_BIT))
            |-> VEC_ADDR == $past(BOOT_START) + 12'h001 + {7'h00, VEC_SOURCE})
        else $error("Moved table offset wrong");

    // The offered source was enabled, pending and unmasked on the offer edge
    enabled_only_a: assert property (@(posedge CLK) disable iff (RST)
        ($rose(VEC_VALID) && !VEC_IS_RESET)
            |-> (($past(IRQ_PENDING & IRQ_ENABLE) >> VEC_SOURCE) & 25'h1) == 25'h1 && $past(GLOBAL_ENABLE))
        else $error("Disabled source dispatched");

    lowest_first_a: assert property (@(posedge CLK) disable iff (RST)
        $rose(VEC_VALID) && !VEC_IS_RESET
            |-> ($past(IRQ_PENDING & IRQ_ENABLE) & ((25'h1 << VEC_SOURCE) - 25'h1)) == 25'h0)
        else $error("Higher vector served first");

    no_offer_boot_a: assert property (@(posedge CLK) disable iff (RST)
        (s_q.st == ST_BOOT && !VEC_TAKEN) |=> VEC_IS_RESET [*1])
        else $error("Reset offer dropped before fetch");

    // A fetched offer is withdrawn on the next edge
    taken_drop_a: assert property (@(posedge CLK) disable iff (RST)
        (VEC_VALID && VEC_TAKEN) |=> !VEC_VALID)
        else $error("Offer stood after fetch");

    // A source that drops its request or enable loses its standing offer
    withdraw_drop_a: assert property (@(posedge CLK) disable iff (RST)
        (VEC_VALID && !VEC_IS_RESET && !(IRQ_PENDING[VEC_SOURCE] && IRQ_ENABLE[VEC_SOURCE])) |=> !VEC_VALID)
        else $error("Withdrawn source still offered");

    // Nothing new is offered while the core masks interrupts
    no_global_a: assert property (@(posedge CLK) disable iff (RST)
        (s_q.st == ST_RUN && !VEC_VALID && !GLOBAL_ENABLE) |=> !VEC_VALID)
        else $error("Offer made with interrupts masked");

    // A standing offer is not replaced by a later request
    offer_stable_a: assert property (@(posedge CLK) disable iff (RST)
        (VEC_VALID && !VEC_TAKEN && !VEC_IS_RESET && IRQ_PENDING[VEC_SOURCE] && IRQ_ENABLE[VEC_SOURCE])
            |=> VEC_VALID && $stable(VEC_ADDR) && $stable(VEC_SOURCE))
        else $error("Standing offer changed before fetch");

    // The reset entry keeps its address until fetched
    boot_hold_a: assert property (@(posedge CLK) disable iff (RST)
        (VEC_IS_RESET && !VEC_TAKEN) |=> VEC_IS_RESET && $stable(VEC_ADDR))
        else $error("Reset entry address moved");

    // The reset entry carries no source index
    reset_source_a: assert property (@(posedge CLK) disable iff (RST)
        (s_q.st == ST_RESET) |=> VEC_SOURCE == 5'h00)
        else $error("Reset entry has a source index");

    reset_seen_c:   cover property (@(posedge CLK) disable iff (RST) VEC_IS_RESET ##1 VEC_TAKEN);
    boot_seen_c:    cover property (@(posedge CLK) disable iff (RST) VEC_IS_RESET && !BOOT_RESET_FUSE);
    moved_seen_c:   cover property (@(posedge CLK) disable iff (RST)
        $rose(VEC_VALID) && !VEC_IS_RESET && VECTOR_SELECT_BIT);
    two_pending_c:  cover property (@(posedge CLK) disable iff (RST)
        $rose(VEC_VALID) && $countones($past(IRQ_PENDING & IRQ_ENABLE)) > 1);
    // Offer dropped without a fetch
    withdraw_seen_c: cover property (@(posedge CLK) disable iff (RST)
        VEC_VALID && !VEC_TAKEN && !VEC_IS_RESET ##1 !VEC_VALID);
endmodule : interrupt_vector_map
`default_nettype wire

// File: testbench/core_fetch_model.sv
/*
 * Processor core model: fetches each offered vector after a set number of cycles.
 * Assumes the map offers on CLK; the fetch pulse changes just after each edge.
 */
`timescale 1ns/10ps
`default_nettype none
module core_fetch_model (
    input  wire logic       CLK,       // Core clock
    input  wire logic       VEC_VALID, // Offer from the map
    input  wire logic [3:0] DELAY,     // Cycles an offer waits before fetch
    output logic            VEC_TAKEN  // One-cycle fetch pulse
);
    int cnt; // Cycles the current offer has stood
    // ==========================================================
    // Fetch pulse; a slow core lets the offer stand for DELAY cycles
    initial begin
        VEC_TAKEN = 1'b0;
        cnt = 0;
        forever begin
            @(posedge CLK);
            #1;
            if (VEC_TAKEN || VEC_VALID !== 1'b1) begin // Pulse ends, or nothing offered
                VEC_TAKEN = 1'b0;
                cnt = 0;
            end else if (cnt >= DELAY) begin // Fetch the offered vector
                VEC_TAKEN = 1'b1;
            end else begin
                cnt++;
            end
        end
    end
endmodule : core_fetch_model
`default_nettype wire

// File: testbench/interrupt_vector_map_tb.sv
/*
 * Self-checking bench for the vector map: reset entries, the full table in
 * both placements, masking and priority. Assumes the core model file.
 */
`timescale 1ns/10ps
`default_nettype none
module interrupt_vector_map_tb;
    import vector_map_pkg::*;
    localparam logic [ADDR_W-1:0] BOOT = 12'h380; // Boot section start used here
    logic                 CLK, RST, BOOT_RESET_FUSE, VECTOR_SELECT_BIT, GLOBAL_ENABLE;
    logic                 VEC_TAKEN, VEC_VALID, VEC_IS_RESET;
    logic [SRC_COUNT-1:0] IRQ_PENDING, IRQ_ENABLE;
    logic [ADDR_W-1:0]    VEC_ADDR;
    logic [SRC_IDX_W-1:0] VEC_SOURCE;
    logic [3:0]           delay;     // Core fetch delay
    int                   n_errors;  // Mismatches
    int                   checked;   // Comparisons
    // ==========================================================
    // Design, core model and clock
    interrupt_vector_map dut (.CLK(CLK), .RST(RST), .BOOT_RESET_FUSE(BOOT_RESET_FUSE),
        .VECTOR_SELECT_BIT(VECTOR_SELECT_BIT), .BOOT_START(BOOT), .IRQ_PENDING(IRQ_PENDING),
        .IRQ_ENABLE(IRQ_ENABLE), .GLOBAL_ENABLE(GLOBAL_ENABLE), .VEC_TAKEN(VEC_TAKEN),
        .VEC_VALID(VEC_VALID), .VEC_IS_RESET(VEC_IS_RESET), .VEC_ADDR(VEC_ADDR), .VEC_SOURCE(VEC_SOURCE));
    core_fetch_model core (.CLK(CLK), .VEC_VALID(VEC_VALID), .DELAY(delay), .VEC_TAKEN(VEC_TAKEN));
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    // ==========================================================
    // Shared tasks
    task automatic step;
        @(posedge CLK);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp) begin // Report the mismatch at once
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic reset_dut(input logic fuse, input logic sel, input logic [11:0] exp);
        RST = 1'b1;
        BOOT_RESET_FUSE = fuse;
        VECTOR_SELECT_BIT = sel;
        repeat (6) step;
        RST = 1'b0;
        step;
        chk("reset valid", 12'h001, 12'(VEC_VALID));
        chk("reset flag", 12'h001, 12'(VEC_IS_RESET));
        chk("reset addr", exp, VEC_ADDR);
        chk("reset source", 12'h000, 12'(VEC_SOURCE));
        repeat (3) step;
    endtask : reset_dut
    // Waits for an offer, checks it, then lets the source clear after the fetch
    task automatic offer(input int idx, input logic [11:0] exp);
        for (int k = 0; k < 20 && VEC_VALID !== 1'b1; k++) step;
        chk("offer valid", 12'h001, 12'(VEC_VALID));
        chk("offer flag", 12'h000, 12'(VEC_IS_RESET));
        chk("offer addr", exp, VEC_ADDR);
        chk("offer source", 12'(idx), 12'(VEC_SOURCE));
        for (int k = 0; k < 20 && VEC_VALID !== 1'b0; k++) step;
        IRQ_PENDING[idx] = 1'b0;
        step;
    endtask : offer
    task automatic quiet;
        repeat (8) begin
            step;
            chk("no offer", 12'h000, 12'(VEC_VALID));
        end
    endtask : quiet
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        reset_dut(1'b1, 1'b0, 12'h000);
        reset_dut(1'b0, 1'b0, BOOT);
        $display("test reset done");
    endtask : t_reset
    task automatic t_table(input logic [11:0] base);
        for (int i = 0; i < SRC_COUNT; i++) begin
            IRQ_PENDING[i] = 1'b1;
            offer(i, base + 12'(i));
        end
        $display("test table %h done", base);
    endtask : t_table
    task automatic t_mask;
        IRQ_ENABLE[5] = 1'b0;
        IRQ_PENDING[5] = 1'b1;
        quiet;
        IRQ_ENABLE[5] = 1'b1;
        GLOBAL_ENABLE = 1'b0;
        quiet;
        GLOBAL_ENABLE = 1'b1;
        offer(5, 12'h006);
        // A slow core leaves time to disable the source before the fetch
        delay = 4'h8;
        IRQ_PENDING[2] = 1'b1;
        for (int k = 0; k < 20 && VEC_VALID !== 1'b1; k++) step;
        chk("withdraw offer", 12'h003, VEC_ADDR);
        IRQ_ENABLE[2] = 1'b0;
        step;
        chk("withdrawn", 12'h000, 12'(VEC_VALID));
        IRQ_PENDING[2] = 1'b0;
        IRQ_ENABLE[2] = 1'b1;
        delay = 4'h0;
        step;
        $display("test mask done");
    endtask : t_mask
    task automatic t_prio;
        delay = 4'h5;
        IRQ_PENDING[24] = 1'b1;
        IRQ_PENDING[3] = 1'b1;
        IRQ_PENDING[7] = 1'b1;
        offer(3, 12'h004);
        offer(7, 12'h008);
        offer(24, 12'h019);
        delay = 4'h0;
        $display("test priority done");
    endtask : t_prio
    // ==========================================================
    // Verdict, watchdog and main sequence
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        #80000;
        n_errors++;
        final_report;
    end
    initial begin
        n_errors = 0;
        checked = 0;
        RST = 1'b1;
        BOOT_RESET_FUSE = 1'b1;
        VECTOR_SELECT_BIT = 1'b0;
        IRQ_PENDING = '0;
        IRQ_ENABLE = '1;
        GLOBAL_ENABLE = 1'b1;
        delay = 4'h0;
        t_reset;
        t_table(12'h001);
        reset_dut(1'b1, 1'b1, 12'h000);
        t_table(BOOT + 12'h001);
        VECTOR_SELECT_BIT = 1'b0;
        t_mask;
        t_prio;
        final_report;
    end
endmodule : interrupt_vector_map_tb
`default_nettype wire
